// [logic/gcsd_cfg.svh]
`ifndef GCSD_CFG_SVH
`define GCSD_CFG_SVH

// ==========================================
// Register offsets
`define GCSD_OFS_SEL1_START 8'h5C
`define GCSD_OFS_SEL1_CTRL 8'h5D
`define GCSD_OFS_SEL2_START 8'h5E
`define GCSD_OFS_SEL2_CTRL 8'h5F
`define GCSD_OFS_AUX_CFG 8'h60
`define GCSD_OFS_STATUS 8'h61

// ==========================================
// Reset values
`define GCSD_RST_START 8'h00
`define GCSD_RST_CTRL 8'h00
`define GCSD_RST_AUX 8'h00

// ==========================================
// Control register fields
`define GCSD_F_MERGE_SEL2 7
`define GCSD_F_MERGE_PROG 6
`define GCSD_F_POL 5
`define GCSD_F_AV 4
`define GCSD_F_SIZE_LSB 0
`define GCSD_SEL2_CTRL_MASK 8'h7F

// ==========================================
// Auxiliary configuration fields
`define GCSD_F_SEL1_XMODE 0
`define GCSD_F_SEL2_XMODE 1
`define GCSD_F_PRIO 2
`define GCSD_F_SEL1_STR_LSB 4
`define GCSD_F_SEL2_STR_LSB 6

// ==========================================
// Size codes and address geometry
`define GCSD_SZ_OFF 4'h0
`define GCSD_SZ_LAST 4'h9
`define GCSD_SZ_WIN1 4'hA
`define GCSD_SZ_WIN2 4'hB
`define GCSD_LOG_BASE 5'h0A
`define GCSD_LOG_MAX 5'h13
`define GCSD_START_LSB 11
`define GCSD_CPU_TOP 15
`define GCSD_EXP_TOP 18

`endif

// [logic/gcsd_pkg.sv]
`include "gcsd_cfg.svh"

package gcsd_pkg;

  typedef logic [3:0] gcsd_size_t;
  typedef logic [7:0] gcsd_byte_t;
  typedef logic [1:0] gcsd_stretch_t;
  typedef logic [4:0] gcsd_log_t;

  typedef enum {
    GCSD_REG_S1A, GCSD_REG_S1C, GCSD_REG_S2A, GCSD_REG_S2C,
    GCSD_REG_AUX, GCSD_REG_STAT, GCSD_REG_NONE
  } gcsd_reg_t;

  // Log2 of the range size for a size code
  function automatic gcsd_log_t gcsd_size_log(input gcsd_size_t code);
    if (code <= `GCSD_SZ_LAST) begin
      gcsd_size_log = 5'(code) + `GCSD_LOG_BASE;
    end else begin
      gcsd_size_log = `GCSD_LOG_MAX;
    end
  endfunction

  // Register select from a bus address
  function automatic gcsd_reg_t gcsd_reg_decode(input gcsd_byte_t a);
    case (a)
      `GCSD_OFS_SEL1_START: gcsd_reg_decode = GCSD_REG_S1A;
      `GCSD_OFS_SEL1_CTRL: gcsd_reg_decode = GCSD_REG_S1C;
      `GCSD_OFS_SEL2_START: gcsd_reg_decode = GCSD_REG_S2A;
      `GCSD_OFS_SEL2_CTRL: gcsd_reg_decode = GCSD_REG_S2C;
      `GCSD_OFS_AUX_CFG: gcsd_reg_decode = GCSD_REG_AUX;
      `GCSD_OFS_STATUS: gcsd_reg_decode = GCSD_REG_STAT;
      default: gcsd_reg_decode = GCSD_REG_NONE;
    endcase
  endfunction

endpackage

// [logic/gcsd_range_match.sv]
`timescale 1ns/100ps
`default_nettype none
`include "gcsd_cfg.svh"

module gcsd_range_match
  import gcsd_pkg::*;
(
  input wire logic [3:0] size_code,
  input wire logic [7:0] start_bits,
  input wire logic exp_mode,
  input wire logic [15:0] cpu_addr,
  input wire logic [18:0] exp_addr,
  input wire logic win1_hit,
  input wire logic win2_hit,
  output logic hit
);

  // ==========================================
  // Per-bit compare above the size boundary
  gcsd_log_t lg;
  logic [7:0] diff;

  assign lg = gcsd_size_log(size_code);

  for (genvar gi = 0; gi < 8; gi++) begin : g_bit
    localparam int B = `GCSD_START_LSB + gi;
    logic abit;
    logic care;
    if (B <= `GCSD_CPU_TOP) begin : g_cpu
      // CPU bit or expansion bit by mode
      assign abit = exp_mode ? exp_addr[B] : cpu_addr[B];
      assign care = (5'(B) >= lg);
    end else begin : g_exp
      // Above bit 15 only expansion mode compares
      assign abit = exp_addr[B];
      assign care = exp_mode && (5'(B) >= lg);
    end
    assign diff[gi] = care & (abit ^ start_bits[gi]);
  end

  // ==========================================
  // Size code selects disable, window or range
  always_comb begin
    case (size_code)
      `GCSD_SZ_OFF: hit = 1'b0;
      `GCSD_SZ_WIN1: hit = win1_hit;
      `GCSD_SZ_WIN2: hit = win2_hit;
      default: hit = ~|diff;
    endcase
  end

endmodule // gcsd_range_match

`default_nettype wire

// [logic/gcsd_decoder.sv]
// Overview of operation
// - Select asserts for whole address-valid time, or only while E is high.
// - Each select has its own polarity bit: one high, zero low.
// - Size code zero disables; codes one to nine 2K..512K; twelve up act 512K.
// - Size codes ten and eleven follow window one or window two, any bank.
// - Start register holds address bits 18..11; clears on reset.
// - Only bits above the range size compare, up to 15 or 18 by mode.
// - Merge bit ORs select one's decode into select two's pin.
// - Select one program-merge bit ORs its decode into the program pin.
// - Select two program-merge bit ORs its decode into the program pin.
// - Select two never drives select one's pin.
// - Select one sent to program: own pin idle, no merge into two.
// - Select two sent to program: its pin idle; select one keeps own pin.
// - All three merge bits: program pin covers all, general pins idle.
// - Merged priority: select one over two; program over both unless priority bit is high.
// - Top bit of select two control is absent and reads zero.
// - Each select offers a stretch of zero to three E cycles in range.
// - Per-select mode bit picks CPU or expansion address compare.
// - Priority bit puts general selects above or below program; on-chip wins.
//
// Design decision made here: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "gcsd_cfg.svh"

module gcsd_decoder
  import gcsd_pkg::*;
#(
  parameter int REG_ADDR_W = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [REG_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [15:0] cpu_addr,
  input wire logic [18:0] exp_addr,
  input wire logic addr_valid,
  input wire logic e_high,
  input wire logic win1_hit,
  input wire logic win2_hit,
  input wire logic onchip_hit,
  input wire logic io_select_hit,
  input wire logic program_range_hit,
  output logic gp_select1_out,
  output logic gp_select2_out,
  output logic program_select_out,
  output logic [1:0] stretch_cycles
);

  // ==========================================
  // Parameter check
  if (REG_ADDR_W < 8) begin : g_chk
    $error("gcsd_decoder: REG_ADDR_W too small for register map");
  end

  // ==========================================
  // Register state
  gcsd_byte_t sel1_start_r;
  gcsd_byte_t sel1_ctrl_r;
  gcsd_byte_t sel2_start_r;
  gcsd_byte_t sel2_ctrl_r;
  gcsd_byte_t aux_cfg_r;
  gcsd_byte_t status_r;
  gcsd_byte_t rdata_nxt;
  gcsd_reg_t reg_sel;

  // Wider addresses alias nothing; upper bits must be zero
  gcsd_byte_t addr_lo;
  logic addr_hi_ok;

  assign addr_lo = reg_addr[7:0];
  assign addr_hi_ok = (reg_addr >> 8) == '0;
  assign reg_sel = addr_hi_ok ? gcsd_reg_decode(addr_lo) : GCSD_REG_NONE;

  // ==========================================
  // Write strobe and shared write decode
  logic wr_stb;

  // Frozen clock enable blocks every write
  assign wr_stb = clk_en & reg_wr;

  // Write hit for one register of the map
  function automatic logic wr_hit(input gcsd_reg_t sel, input gcsd_reg_t which, input logic stb);
    wr_hit = stb && (sel == which);
  endfunction

  // ==========================================
  // Control fields
  logic sel1_merge_into_sel2;
  logic sel1_merge_into_program;
  logic sel2_merge_into_program;
  logic sel1_polarity;
  logic sel2_polarity;
  logic sel1_addr_valid_timing;
  logic sel2_addr_valid_timing;
  gcsd_size_t sel1_size_code;
  gcsd_size_t sel2_size_code;
  logic sel1_expansion_addr_mode;
  logic sel2_expansion_addr_mode;
  logic gp_over_program_priority;
  gcsd_stretch_t sel1_stretch;
  gcsd_stretch_t sel2_stretch;

  assign sel1_merge_into_sel2 = sel1_ctrl_r[`GCSD_F_MERGE_SEL2];
  assign sel1_merge_into_program = sel1_ctrl_r[`GCSD_F_MERGE_PROG];
  assign sel2_merge_into_program = sel2_ctrl_r[`GCSD_F_MERGE_PROG];
  assign sel1_polarity = sel1_ctrl_r[`GCSD_F_POL];
  assign sel2_polarity = sel2_ctrl_r[`GCSD_F_POL];
  assign sel1_addr_valid_timing = sel1_ctrl_r[`GCSD_F_AV];
  assign sel2_addr_valid_timing = sel2_ctrl_r[`GCSD_F_AV];
  assign sel1_size_code = sel1_ctrl_r[`GCSD_F_SIZE_LSB +: 4];
  assign sel2_size_code = sel2_ctrl_r[`GCSD_F_SIZE_LSB +: 4];
  assign sel1_expansion_addr_mode = aux_cfg_r[`GCSD_F_SEL1_XMODE];
  assign sel2_expansion_addr_mode = aux_cfg_r[`GCSD_F_SEL2_XMODE];
  assign gp_over_program_priority = aux_cfg_r[`GCSD_F_PRIO];
  assign sel1_stretch = aux_cfg_r[`GCSD_F_SEL1_STR_LSB +: 2];
  assign sel2_stretch = aux_cfg_r[`GCSD_F_SEL2_STR_LSB +: 2];

  // ==========================================
  // Register writes

  // Select one start address
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sel1_start_r <= `GCSD_RST_START;
    end else if (wr_hit(reg_sel, GCSD_REG_S1A, wr_stb)) begin
      sel1_start_r <= reg_wdata;
    end
  end

  // Select one control
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sel1_ctrl_r <= `GCSD_RST_CTRL;
    end else if (wr_hit(reg_sel, GCSD_REG_S1C, wr_stb)) begin
      sel1_ctrl_r <= reg_wdata;
    end
  end

  // Select two start address
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sel2_start_r <= `GCSD_RST_START;
    end else if (wr_hit(reg_sel, GCSD_REG_S2A, wr_stb)) begin
      sel2_start_r <= reg_wdata;
    end
  end

  // Select two control, top bit held at zero
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sel2_ctrl_r <= `GCSD_RST_CTRL;
    end else if (wr_hit(reg_sel, GCSD_REG_S2C, wr_stb)) begin
      sel2_ctrl_r <= reg_wdata & `GCSD_SEL2_CTRL_MASK;
    end
  end

  // Mode, priority and stretch settings
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      aux_cfg_r <= `GCSD_RST_AUX;
    end else if (wr_hit(reg_sel, GCSD_REG_AUX, wr_stb)) begin
      aux_cfg_r <= reg_wdata;
    end
  end

  // ==========================================
  // Range decode for both selects
  logic sel1_range;
  logic sel2_range;

  gcsd_range_match u_match1 (
    .size_code(sel1_size_code),
    .start_bits(sel1_start_r),
    .exp_mode(sel1_expansion_addr_mode),
    .cpu_addr(cpu_addr),
    .exp_addr(exp_addr),
    .win1_hit(win1_hit),
    .win2_hit(win2_hit),
    .hit(sel1_range)
  );

  gcsd_range_match u_match2 (
    .size_code(sel2_size_code),
    .start_bits(sel2_start_r),
    .exp_mode(sel2_expansion_addr_mode),
    .cpu_addr(cpu_addr),
    .exp_addr(exp_addr),
    .win1_hit(win1_hit),
    .win2_hit(win2_hit),
    .hit(sel2_range)
  );

  // ==========================================
  // Priority among on-chip, I/O, program and general
  logic higher_hit;
  logic prog_blocks_gp;
  logic sel1_win;
  logic sel2_win;
  logic prog_win;

  // On-chip resources and I/O select outrank all three
  assign higher_hit = onchip_hit | io_select_hit;
  // Program wins over general selects when priority bit is low
  assign prog_blocks_gp = program_range_hit & ~gp_over_program_priority;
  // Select one outranks select two where ranges overlap
  assign sel1_win = sel1_range & ~higher_hit & ~prog_blocks_gp;
  assign sel2_win = sel2_range & ~sel1_range & ~higher_hit & ~prog_blocks_gp;
  // General selects push program aside when priority bit is high
  assign prog_win = program_range_hit & ~higher_hit
                    & ~(gp_over_program_priority & (sel1_range | sel2_range));

  // ==========================================
  // Timing qualification
  logic sel1_timed;
  logic sel2_timed;
  logic prog_timed;

  // Address-valid timing or E-high only
  assign sel1_timed = sel1_win & addr_valid & (sel1_addr_valid_timing | e_high);
  assign sel2_timed = sel2_win & addr_valid & (sel2_addr_valid_timing | e_high);
  // Program select is fixed to address-valid timing
  assign prog_timed = prog_win & addr_valid;

  // ==========================================
  // Merge routing
  logic sel1_to_prog;
  logic sel1_to_sel2;
  logic sel1_own_pin;
  logic sel2_own_pin;
  logic pin1_active;
  logic pin2_active;
  logic prog_active;

  // Program merge of select one overrides its other paths
  assign sel1_to_prog = sel1_merge_into_program;
  // Merge into two is void when either is sent to program
  assign sel1_to_sel2 = sel1_merge_into_sel2 & ~sel1_merge_into_program
                        & ~sel2_merge_into_program;
  // Select one keeps its own pin unless routed elsewhere
  assign sel1_own_pin = ~sel1_to_prog & ~sel1_to_sel2;
  // Select two pin idle when routed to program
  assign sel2_own_pin = ~sel2_merge_into_program;

  // Select one pin never sees select two
  assign pin1_active = sel1_timed & sel1_own_pin;
  assign pin2_active = sel2_own_pin & (sel2_timed | (sel1_timed & sel1_to_sel2));
  assign prog_active = prog_timed
                       | (sel1_timed & sel1_to_prog)
                       | (sel2_timed & sel2_merge_into_program);

  // ==========================================
  // Pin levels after polarity
  logic gp_select1_nxt;
  logic gp_select2_nxt;
  logic program_select_nxt;

  // Polarity bit one gives active high
  assign gp_select1_nxt = ~(pin1_active ^ sel1_polarity);
  assign gp_select2_nxt = ~(pin2_active ^ sel2_polarity);
  // Program pin is fixed active low
  assign program_select_nxt = ~prog_active;

  // ==========================================
  // Output pins, one flip-flop each

  // Select one pin, idle high out of reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      gp_select1_out <= 1'b1;
    end else if (clk_en) begin
      gp_select1_out <= gp_select1_nxt;
    end
  end

  // Select two pin, idle high out of reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      gp_select2_out <= 1'b1;
    end else if (clk_en) begin
      gp_select2_out <= gp_select2_nxt;
    end
  end

  // Program pin, idle high out of reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      program_select_out <= 1'b1;
    end else if (clk_en) begin
      program_select_out <= program_select_nxt;
    end
  end

  // ==========================================
  // Stretch request for the access in range
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stretch_cycles <= 2'h0;
    end else if (clk_en) begin
      if (sel1_win & addr_valid) begin
        stretch_cycles <= sel1_stretch;
      end else if (sel2_win & addr_valid) begin
        stretch_cycles <= sel2_stretch;
      end else begin
        stretch_cycles <= 2'h0;
      end
    end
  end

  // ==========================================
  // Status capture of decode results
  // Bits: program pin, pin two, pin one, program win, ranges
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      status_r <= 8'h00;
    end else if (clk_en) begin
      status_r <= {2'h0, prog_active, pin2_active, pin1_active,
                   prog_win, sel2_range, sel1_range};
    end
  end

  // ==========================================
  // Read mux
  always_comb begin
    case (reg_sel)
      GCSD_REG_S1A: rdata_nxt = sel1_start_r;
      GCSD_REG_S1C: rdata_nxt = sel1_ctrl_r;
      GCSD_REG_S2A: rdata_nxt = sel2_start_r;
      GCSD_REG_S2C: rdata_nxt = sel2_ctrl_r & `GCSD_SEL2_CTRL_MASK;
      GCSD_REG_AUX: rdata_nxt = aux_cfg_r;
      GCSD_REG_STAT: rdata_nxt = status_r;
      default: rdata_nxt = 8'h00;
    endcase
  end

  // Read data stand one cycle after the strobe only
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      reg_rdata <= reg_rd ? rdata_nxt : 8'h00;
    end
  end

endmodule // gcsd_decoder

`default_nettype wire

// [verification/gcsd_decoder_chk.sv]
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Port checker for the chip-select decoder
module gcsd_decoder_chk #(
  parameter int REG_ADDR_W = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [REG_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic addr_valid,
  input wire logic e_high,
  input wire logic onchip_hit,
  input wire logic io_select_hit,
  input wire logic gp_select1_out,
  input wire logic gp_select2_out,
  input wire logic program_select_out
);
  logic [7:0] c1_r;
  logic [7:0] c2_r;
  // Shadow copies of both control registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      c1_r <= 8'h00;
      c2_r <= 8'h00;
    end else if (clk_en && reg_wr) begin
      if (reg_addr == REG_ADDR_W'(8'h5D)) c1_r <= reg_wdata;
      if (reg_addr == REG_ADDR_W'(8'h5F)) c2_r <= reg_wdata & 8'h7F;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ==========================================
  // Assertions
  ctrl2_top_zero_a: assert property ($past(clk_en && reg_rd && reg_addr == REG_ADDR_W'(8'h5F)) |-> !reg_rdata[7])
    else $error("select 2 control top bit reads one");
  onchip_quiet_a: assert property ($past(clk_en && (onchip_hit || io_select_hit)) |-> program_select_out
    && gp_select1_out == !$past(c1_r[5]) && gp_select2_out == !$past(c2_r[5])) else $error("select during on-chip");
  valid_gate_a: assert property ($past(clk_en && !addr_valid) |-> program_select_out
    && gp_select1_out == !$past(c1_r[5]) && gp_select2_out == !$past(c2_r[5])) else $error("select without valid");
  sel1_ehigh_a: assert property ($past(clk_en && !c1_r[4] && !e_high) |-> gp_select1_out == !$past(c1_r[5]))
    else $error("select 1 outside E high");
  sel1_to_prog_a: assert property ($past(clk_en && c1_r[6]) |-> gp_select1_out == !$past(c1_r[5]))
    else $error("select 1 pin active while merged");
  sel2_to_prog_a: assert property ($past(clk_en && c2_r[6]) |-> gp_select2_out == !$past(c2_r[5]))
    else $error("select 2 pin active while merged");
  all_merge_a: assert property ($past(clk_en && c1_r[7] && c1_r[6] && c2_r[6]) |->
    gp_select1_out == !$past(c1_r[5]) && gp_select2_out == !$past(c2_r[5])) else $error("general pin active");
  sel1_off_a: assert property ($past(clk_en && c1_r[3:0] == 4'h0) |-> gp_select1_out == !$past(c1_r[5]))
    else $error("disabled select 1 pin active");
  cover property (!gp_select1_out && !c1_r[5]);
  cover property (!program_select_out && c2_r[6]);
  cover property (gp_select2_out == c2_r[5] && c1_r[7]);
endmodule // gcsd_decoder_chk

bind gcsd_decoder gcsd_decoder_chk #(.REG_ADDR_W(REG_ADDR_W)) u_chk (.ref_clk(ref_clk), .rst(rst),
  .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .addr_valid(addr_valid), .e_high(e_high), .onchip_hit(onchip_hit),
  .io_select_hit(io_select_hit), .gp_select1_out(gp_select1_out), .gp_select2_out(gp_select2_out),
  .program_select_out(program_select_out));
`default_nettype wire

// [verification/gcsd_ext_dev.sv]
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// External device on select 1, counts its selections
module gcsd_ext_dev #(
  parameter logic ACT = 1'b0
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sel,
  output logic [7:0] hits
);
  logic prev_r;
  // New selection when the pin turns active
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prev_r <= 1'b0;
      hits <= 8'h00;
    end else begin
      prev_r <= (sel == ACT);
      if (sel == ACT && !prev_r) hits <= hits + 8'h01;
    end
  end
endmodule // gcsd_ext_dev
`default_nettype wire

// [verification/gcsd_decoder_tb.sv]
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Self-checking bench for the decoder
module gcsd_decoder_tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] cpu_addr = 16'h0000;
  logic [18:0] exp_addr = 19'h00000;
  logic addr_valid = 1'b0;
  logic e_high = 1'b1;
  logic win1_hit = 1'b0;
  logic win2_hit = 1'b0;
  logic onchip_hit = 1'b0;
  logic io_select_hit = 1'b0;
  logic program_range_hit = 1'b0;
  logic [7:0] reg_rdata;
  logic gp_select1_out;
  logic gp_select2_out;
  logic program_select_out;
  logic [1:0] stretch_cycles;
  logic [7:0] hits;
  logic [7:0] d;
  logic [7:0] n;
  logic q;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  gcsd_decoder uut (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_addr(cpu_addr), .exp_addr(exp_addr),
    .addr_valid(addr_valid), .e_high(e_high), .win1_hit(win1_hit), .win2_hit(win2_hit),
    .onchip_hit(onchip_hit), .io_select_hit(io_select_hit), .program_range_hit(program_range_hit),
    .gp_select1_out(gp_select1_out), .gp_select2_out(gp_select2_out),
    .program_select_out(program_select_out), .stretch_cycles(stretch_cycles));
  gcsd_ext_dev dev (.ref_clk(ref_clk), .rst(rst), .sel(gp_select1_out), .hits(hits));
  // Clock and hang guard
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk("rdata", reg_rdata, exp);
  endtask
  // One valid access; ex holds program, select 2, select 1 pin levels
  task automatic acc(input logic [15:0] ca, input logic [2:0] ex, input logic [1:0] st);
    @(posedge ref_clk);
    cpu_addr <= ca;
    addr_valid <= 1'b1;
    @(posedge ref_clk);
    #1 chk("pins", {5'h00, program_select_out, gp_select2_out, gp_select1_out}, {5'h00, ex});
    chk("stretch", {6'h00, stretch_cycles}, {6'h00, st});
    @(posedge ref_clk);
    addr_valid <= 1'b0;
  endtask
  // ==========================================
  // Test sequence
  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) rd(8'h5C + 8'(i), 8'h00);
    wr(8'h5F, 8'hFF);
    rd(8'h5F, 8'h7F);
    wr(8'h5C, 8'hA5);
    rd(8'h5C, 8'hA5);
    rd(8'h70, 8'h00);
    $display("Test registers done");
    wr(8'h5F, 8'h00);
    wr(8'h5C, 8'h11);
    wr(8'h5D, 8'h11);
    n = hits;
    acc(16'h8800, 3'b110, 2'd0);
    acc(16'h8FFF, 3'b110, 2'd0);
    acc(16'h9000, 3'b111, 2'd0);
    acc(16'h0800, 3'b111, 2'd0);
    chk("device", hits, n + 8'h02);
    wr(8'h5D, 8'h01);
    e_high <= 1'b0;
    acc(16'h8800, 3'b111, 2'd0);
    e_high <= 1'b1;
    acc(16'h8800, 3'b110, 2'd0);
    wr(8'h5D, 8'h31);
    acc(16'h8800, 3'b111, 2'd0);
    acc(16'h9000, 3'b110, 2'd0);
    $display("Test select 1 done");
    wr(8'h5C, 8'h00);
    for (int c = 0; c < 16; c++) begin
      if (c != 10 && c != 11) begin
        wr(8'h5D, 8'h10 | 8'(c));
        acc(16'h8000, {2'b11, !(c >= 6)}, 2'd0);
        acc(16'h07FF, {2'b11, c == 0}, 2'd0);
      end
    end
    wr(8'h5D, 8'h1A);
    win1_hit <= 1'b1;
    acc(16'h4000, 3'b110, 2'd0);
    win1_hit <= 1'b0;
    acc(16'h4000, 3'b111, 2'd0);
    wr(8'h5D, 8'h1B);
    win2_hit <= 1'b1;
    acc(16'h4000, 3'b110, 2'd0);
    win2_hit <= 1'b0;
    wr(8'h60, 8'h01);
    wr(8'h5C, 8'h91);
    wr(8'h5D, 8'h11);
    exp_addr <= 19'h48800;
    acc(16'h0000, 3'b110, 2'd0);
    exp_addr <= 19'h48000;
    acc(16'h0000, 3'b111, 2'd0);
    wr(8'h60, 8'h00);
    $display("Test sizes done");
    wr(8'h5C, 8'h11);
    wr(8'h5E, 8'h12);
    for (int m = 0; m < 8; m++) begin
      wr(8'h5D, {m[2], m[1], 6'h11});
      wr(8'h5F, {1'b0, m[0], 6'h11});
      q = m[2] & !m[1] & !m[0];
      acc(16'h8800, {!m[1], !q, m[1] | q}, 2'd0);
      acc(16'h9000, {!m[0], m[0], 1'b1}, 2'd0);
    end
    $display("Test merging done");
    wr(8'h5D, 8'h11);
    wr(8'h5F, 8'h11);
    program_range_hit <= 1'b1;
    acc(16'h8800, 3'b011, 2'd0);
    wr(8'h60, 8'h04);
    acc(16'h8800, 3'b110, 2'd0);
    onchip_hit <= 1'b1;
    acc(16'h8800, 3'b111, 2'd0);
    onchip_hit <= 1'b0;
    io_select_hit <= 1'b1;
    acc(16'h8800, 3'b111, 2'd0);
    io_select_hit <= 1'b0;
    program_range_hit <= 1'b0;
    wr(8'h5E, 8'h11);
    acc(16'h8800, 3'b110, 2'd0);
    wr(8'h5E, 8'h12);
    wr(8'h60, 8'hB0);
    acc(16'h8800, 3'b110, 2'd3);
    rd(8'h61, 8'h01);
    acc(16'h9000, 3'b101, 2'd2);
    acc(16'h0000, 3'b111, 2'd0);
    wr(8'h5F, 8'h31);
    acc(16'h9000, 3'b111, 2'd2);
    acc(16'h8800, 3'b100, 2'd3);
    clk_en <= 1'b0;
    wr(8'h5C, 8'h3C);
    clk_en <= 1'b1;
    rd(8'h5C, 8'h11);
    $display("Test priority and stretch done");
    wrap_up();
  end
endmodule // gcsd_decoder_tb
`default_nettype wire
